//--- design/pport_params.svh
// Constants of the printer parallel port: register indices, bit positions, reset values
// Overview of operation
// RULE1: Printer select low enables port registers
// RULE2: Index lines pick register; select picks port
// RULE3: Write strobe low captures host byte
// RULE4: Read strobe low drives register onto bus
// RULE5: Buffer direction high while selected and driving
// RULE6: Printer data tristated while input direction high
// RULE7: Latch pulse tells printer to latch data
// RULE8: Autofeed request advances continuous paper
// RULE9: Restart request low starts printer initialization
// RULE10: Select request low selects the printer
// RULE11: Interrupt driven only when control bit 4
// RULE12: Variant A: irq follows confirm edges
// RULE13: Variant B: low on rise, released by read
// RULE14: Printer drives fault low on error
// RULE15: Printer raises online once selected
// RULE16: Printer holds busy high while working
// RULE17: Printer raises paper out when empty
// RULE18: Printer pulses confirm low on acceptance
// RULE19: Status read returns live printer input levels
// RULE20: Printer control outputs come from control bits
`ifndef PPORT_PARAMS_SVH
`define PPORT_PARAMS_SVH

// Register indices on the index lines
`define PPORT_IDX_DATA      3'h0
`define PPORT_IDX_STATUS    3'h1
`define PPORT_IDX_CONTROL   3'h2

// Control register bit positions; a set bit asserts the line
`define PPORT_CTL_LATCH     0
`define PPORT_CTL_FEED      1
`define PPORT_CTL_RESTART   2
`define PPORT_CTL_SELECT    3
`define PPORT_CTL_IRQ_EN    4
`define PPORT_CTL_WIDTH     5
`define PPORT_CTL_RESET     5'h00

// Status register bit positions
`define PPORT_ST_IRQ        2
`define PPORT_ST_FAULT_N    3
`define PPORT_ST_ONLINE     4
`define PPORT_ST_PAPER_OUT  5
`define PPORT_ST_CONFIRM_N  6
`define PPORT_ST_BUSY       7

// Buffer depth and data reset value
`define PPORT_BUF_DEPTH     2
`define PPORT_DATA_RESET    8'h00

`endif

//--- design/pport_pkg.sv
// Types shared by the printer parallel port
package pport_pkg;
  // Interrupt behaviour of the two device variants
  typedef enum logic {
    PPORT_IRQ_FOLLOW  = 1'b0,
    PPORT_IRQ_LATCHED = 1'b1
  } pport_irq_variant_type;

  typedef logic [2:0] pport_index_type;
endpackage

//--- design/pport_top.sv
// Printer parallel port: host register decode, data buffer, printer lines, interrupt
`timescale 1ns/10ps
`default_nettype none
`include "pport_params.svh"

module pport_top #(
  parameter pport_pkg::pport_irq_variant_type IRQ_VARIANT = pport_pkg::PPORT_IRQ_FOLLOW,
  parameter int                               DATA_W      = 8
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Host bus
  input  wire logic                       printer_port_select_n,
  input  wire logic                       serial_port_select_n,
  input  wire pport_pkg::pport_index_type register_index_lines,
  input  wire logic                       io_write_strobe_n,
  input  wire logic                       io_read_strobe_n,
  input  wire logic [DATA_W-1:0]          host_bus_in,
  output logic [DATA_W-1:0]               host_bus_out,
  output logic                            host_bus_oe,
  output logic                            bus_buffer_direction,
  output logic                            data_write_ready,
  // Printer data lines
  input  wire logic                       port_input_dir_enable,
  input  wire logic [DATA_W-1:0]          printer_data_in,
  output logic [DATA_W-1:0]               printer_data_out,
  output logic                            printer_data_oe,
  // Printer control outputs, all active low
  output logic                            data_latch_pulse_n,
  output logic                            auto_feed_request_n,
  output logic                            printer_restart_request_n,
  output logic                            printer_select_request_n,
  // Printer status inputs
  input  wire logic                       printer_fault_n,
  input  wire logic                       printer_online,
  input  wire logic                       busy,
  input  wire logic                       paper_out,
  input  wire logic                       transfer_confirm_n,
  // Printer interrupt, three-state
  output logic                            printer_irq,
  output logic                            printer_irq_oe
);
  import pport_pkg::*;

  // Host access decode
  wire logic port_sel   = ~printer_port_select_n;                        // RULE1
  wire logic any_sel    = port_sel | ~serial_port_select_n;
  wire logic sel_data   = port_sel & (register_index_lines == `PPORT_IDX_DATA);    // RULE2
  wire logic sel_status = port_sel & (register_index_lines == `PPORT_IDX_STATUS);  // RULE2
  wire logic sel_ctl    = port_sel & (register_index_lines == `PPORT_IDX_CONTROL); // RULE2
  wire logic rd_active  = ~io_read_strobe_n;
  wire logic wr_active  = ~io_write_strobe_n;

  // Strobe history for edge detection
  logic                       wr_prev_reg;
  logic                       rd_prev_reg;
  logic                       confirm_prev_reg;
  logic                       status_read_reg;
  logic [`PPORT_CTL_WIDTH-1:0] ctl_reg;
  logic                       irq_reg;

  // A write is taken once, on the first cycle the strobe is low
  wire logic wr_start    = wr_active & ~wr_prev_reg;                     // RULE3
  wire logic rd_end      = ~rd_active & rd_prev_reg;
  wire logic confirm_hi  = transfer_confirm_n;
  wire logic confirm_rise = confirm_hi & ~confirm_prev_reg;
  wire logic confirm_fall = ~confirm_hi & confirm_prev_reg;

  // Two-entry buffer between host writes and the printer data latch
  logic [DATA_W-1:0] buf_mem [`PPORT_BUF_DEPTH];
  logic              buf_wr_ptr_reg;
  logic              buf_rd_ptr_reg;
  logic [1:0]        buf_count_reg;
  logic [1:0]        buf_count_next;
  logic              buf_full_reg;
  logic [DATA_W-1:0] pdata_reg;

  // Printer busy stalls the drain, so host writes back up and get refused
  wire logic buf_push  = wr_start & sel_data & ~buf_full_reg;
  wire logic buf_valid = (buf_count_reg != 2'h0);
  wire logic buf_ready = ~busy;
  wire logic buf_pop   = buf_valid & buf_ready;
  assign buf_count_next = buf_count_reg + {1'b0, buf_push} - {1'b0, buf_pop};

  always_ff @(posedge clk) begin
    if (buf_push) begin
      buf_mem[buf_wr_ptr_reg] <= host_bus_in;                            // RULE3
    end
  end

  // Buffer pointers and occupancy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
      buf_count_reg  <= 2'h0;
      buf_full_reg   <= 1'b0;
    end else begin
      buf_wr_ptr_reg <= buf_wr_ptr_reg ^ buf_push;
      buf_rd_ptr_reg <= buf_rd_ptr_reg ^ buf_pop;
      buf_count_reg  <= buf_count_next;
      buf_full_reg   <= (buf_count_next == 2'(`PPORT_BUF_DEPTH));
    end
  end

  // Printer data latch, loaded as the buffer drains
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pdata_reg <= `PPORT_DATA_RESET;
    end else if (buf_pop) begin
      pdata_reg <= buf_mem[buf_rd_ptr_reg];
    end
  end

  // Control register: host writes drive the printer control lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_reg <= `PPORT_CTL_RESET;
    end else if (wr_start && sel_ctl) begin
      ctl_reg <= host_bus_in[`PPORT_CTL_WIDTH-1:0];                      // RULE3 RULE20
    end
  end

  // Status image; live levels of the printer inputs
  wire logic [DATA_W-1:0] status_word;
  assign status_word = {busy, transfer_confirm_n, paper_out, printer_online,
                        printer_fault_n, irq_reg, 2'h0};                 // RULE19
  wire logic [DATA_W-1:0] data_word = port_input_dir_enable ? printer_data_in : pdata_reg;
  wire logic [DATA_W-1:0] ctl_word  = {{(DATA_W-`PPORT_CTL_WIDTH){1'b0}}, ctl_reg};
  wire logic [DATA_W-1:0] rd_word   = sel_data   ? data_word :
                                      sel_status ? status_word :
                                      sel_ctl    ? ctl_word : {DATA_W{1'b0}};

  // Host bus answer and transceiver direction, one cycle behind the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_bus_out         <= {DATA_W{1'b0}};
      host_bus_oe          <= 1'b0;
      bus_buffer_direction <= 1'b0;
      data_write_ready     <= 1'b0;
    end else begin
      host_bus_out         <= rd_word;                                   // RULE4
      host_bus_oe          <= rd_active & port_sel;                      // RULE4
      bus_buffer_direction <= rd_active & any_sel;                       // RULE5
      data_write_ready     <= ~buf_full_reg & ~(buf_push & (buf_count_reg != 2'h0));
    end
  end

  // Printer data lines and control outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      printer_data_out          <= `PPORT_DATA_RESET;
      printer_data_oe           <= 1'b0;
      data_latch_pulse_n        <= 1'b1;
      auto_feed_request_n       <= 1'b1;
      printer_restart_request_n <= 1'b1;
      printer_select_request_n  <= 1'b1;
    end else begin
      printer_data_out          <= pdata_reg;
      printer_data_oe           <= ~port_input_dir_enable;               // RULE6
      data_latch_pulse_n        <= ~ctl_reg[`PPORT_CTL_LATCH];           // RULE7
      auto_feed_request_n       <= ~ctl_reg[`PPORT_CTL_FEED];            // RULE8
      printer_restart_request_n <= ~ctl_reg[`PPORT_CTL_RESTART];         // RULE9
      printer_select_request_n  <= ~ctl_reg[`PPORT_CTL_SELECT];          // RULE10
    end
  end

  // Edge history; a status read is remembered until its strobe rises
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_prev_reg      <= 1'b0;
      rd_prev_reg      <= 1'b0;
      confirm_prev_reg <= 1'b1;
      status_read_reg  <= 1'b0;
    end else begin
      wr_prev_reg      <= wr_active;
      rd_prev_reg      <= rd_active;
      confirm_prev_reg <= confirm_hi;
      status_read_reg  <= rd_active & (sel_status | status_read_reg);
    end
  end

  // Interrupt state; in the latched variant a confirm rise beats a clearing read
  wire logic irq_next_follow  = confirm_rise ? 1'b1 : confirm_fall ? 1'b0 : irq_reg;
  wire logic irq_next_latched = confirm_rise ? 1'b0 :
                                (rd_end && status_read_reg) ? 1'b1 : irq_reg;
  wire logic irq_latched_mode = (IRQ_VARIANT == PPORT_IRQ_LATCHED);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_reg        <= 1'b0;
      printer_irq    <= 1'b0;
      printer_irq_oe <= 1'b0;
    end else begin
      irq_reg        <= irq_latched_mode ? irq_next_latched : irq_next_follow; // RULE12 RULE13
      printer_irq    <= irq_reg;
      printer_irq_oe <= ctl_reg[`PPORT_CTL_IRQ_EN];                      // RULE11
    end
  end

  // Checks
  sequence s_confirm_rise;
    !$past(transfer_confirm_n) && transfer_confirm_n;
  endsequence

  sequence s_status_read_end;
    !io_read_strobe_n ##1 io_read_strobe_n;
  endsequence

  a_irq_follow_rise: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    ((!irq_latched_mode) and s_confirm_rise) |-> ##2 printer_irq)
    else $error("irq did not rise after confirm rise");

  a_irq_follow_fall: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    (!irq_latched_mode && $past(transfer_confirm_n) && !transfer_confirm_n
     && !(rst_n && !$past(rst_n))) |-> ##2 !printer_irq)
    else $error("irq did not fall after confirm fall");

  a_irq_latch_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    (irq_latched_mode and s_confirm_rise) |-> ##2 !printer_irq)
    else $error("latched irq did not go low");

  // A confirm rise in the same cycle wins over the release, so only a steady confirm counts
  a_irq_latch_release: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    (irq_latched_mode && status_read_reg) ##0 s_status_read_end
    ##0 $stable(transfer_confirm_n) |-> ##2 printer_irq)
    else $error("status read did not release irq");

  a_irq_enable: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    $rose(ctl_reg[`PPORT_CTL_IRQ_EN]) |=> printer_irq_oe)
    else $error("irq driver not enabled by control bit");

  a_data_tristate: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    port_input_dir_enable ##1 port_input_dir_enable |-> !printer_data_oe)
    else $error("printer data driven while input direction");

  a_ctl_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
    (wr_start && sel_ctl) |-> ##2 (printer_restart_request_n ==
      !$past(host_bus_in[`PPORT_CTL_RESTART], 2)))
    else $error("restart request does not follow control write");

  a_status_read: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    (rd_active && sel_status) |=> host_bus_oe &&
      host_bus_out[`PPORT_ST_BUSY] == $past(busy))
    else $error("status read does not show busy");

  a_buf_direction: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    (rd_active && !serial_port_select_n) |=> bus_buffer_direction)
    else $error("bus buffer direction not asserted");

  a_no_select_no_drive: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    printer_port_select_n |=> !host_bus_oe)
    else $error("bus driven without printer select");
endmodule

`default_nettype wire

//--- verif/pport_printer_model.sv
// Behavioural line printer that answers the parallel port's control lines
`timescale 1ns/10ps
`default_nettype none
module pport_printer_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Lines driven by the port
  input  wire logic data_latch_pulse_n,
  input  wire logic printer_select_request_n,
  // Bench controls: hold busy, empty the paper tray
  input  wire logic stall,
  input  wire logic no_paper,
  // Status lines back to the port
  output logic      printer_fault_n,
  output logic      printer_online,
  output logic      busy,
  output logic      paper_out,
  output logic      transfer_confirm_n
);
  logic       latch_reg;
  logic [1:0] ack_reg;
  // Status levels; a deselected or paper-less printer reports a fault
  assign printer_online     = !printer_select_request_n;
  assign paper_out          = no_paper;
  assign printer_fault_n    = printer_online && !paper_out;
  assign busy               = stall || (ack_reg != 2'h0);
  assign transfer_confirm_n = (ack_reg == 2'h0);
  // Confirm pulse of three cycles starts at the latch pulse's leading edge
  always_ff @(posedge clk) begin
    latch_reg <= data_latch_pulse_n;
    if (!rst_n) begin
      ack_reg <= 2'h0;
    end else if (latch_reg && !data_latch_pulse_n) begin
      ack_reg <= 2'h3;
    end else if (ack_reg != 2'h0) begin
      ack_reg <= ack_reg - 2'h1;
    end
  end
endmodule
`default_nettype wire

//--- verif/pport_top_tb_top.sv
// Self-checking bench for the printer parallel port with a printer model
`timescale 1ns/10ps
`default_nettype none
module pport_top_tb_top;
  import pport_pkg::*;
  // Bench signals, named as the ports they meet
  logic            clk, rst_n, printer_port_select_n, serial_port_select_n, stall, no_paper;
  logic            io_write_strobe_n, io_read_strobe_n, port_input_dir_enable;
  pport_index_type register_index_lines;
  logic [7:0]      host_bus_in, host_bus_out, printer_data_in, printer_data_out, d;
  logic            host_bus_oe, bus_buffer_direction, data_write_ready, printer_data_oe;
  logic            data_latch_pulse_n, auto_feed_request_n, printer_restart_request_n;
  logic            printer_select_request_n, printer_fault_n, printer_online, busy, paper_out;
  logic            transfer_confirm_n, printer_irq, printer_irq_oe, oe_s, dir_s, irq_b;
  logic [3:0]      ctl_n;
  int              err_total, n_tests, cycles;
  // Control lines gathered latch, feed, restart, select
  assign ctl_n = {data_latch_pulse_n, auto_feed_request_n, printer_restart_request_n,
                  printer_select_request_n};
  // Printer drives its data lines only while the port has let go of them
  assign printer_data_in = printer_data_oe ? printer_data_out : 8'h3c;
  pport_top i_dut (
    .clk, .rst_n, .printer_port_select_n, .serial_port_select_n, .register_index_lines,
    .io_write_strobe_n, .io_read_strobe_n, .host_bus_in, .host_bus_out, .host_bus_oe,
    .bus_buffer_direction, .data_write_ready, .port_input_dir_enable, .printer_data_in,
    .printer_data_out, .printer_data_oe, .data_latch_pulse_n, .auto_feed_request_n,
    .printer_restart_request_n, .printer_select_request_n, .printer_fault_n, .printer_online,
    .busy, .paper_out, .transfer_confirm_n, .printer_irq, .printer_irq_oe
  );
  // Second port in the latched interrupt variant, fed the same host and printer lines
  pport_top #(.IRQ_VARIANT(PPORT_IRQ_LATCHED)) i_dut_b (
    .clk, .rst_n, .printer_port_select_n, .serial_port_select_n, .register_index_lines,
    .io_write_strobe_n, .io_read_strobe_n, .host_bus_in, .host_bus_out(), .host_bus_oe(),
    .bus_buffer_direction(), .data_write_ready(), .port_input_dir_enable, .printer_data_in,
    .printer_data_out(), .printer_data_oe(), .data_latch_pulse_n(), .auto_feed_request_n(),
    .printer_restart_request_n(), .printer_select_request_n(), .printer_fault_n,
    .printer_online, .busy, .paper_out, .transfer_confirm_n, .printer_irq(irq_b),
    .printer_irq_oe()
  );
  pport_printer_model i_printer (
    .clk, .rst_n, .data_latch_pulse_n, .printer_select_request_n, .stall, .no_paper,
    .printer_fault_n, .printer_online, .busy, .paper_out, .transfer_confirm_n
  );
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Host write: strobe falls after an edge, held two edges, then settle time
  task automatic wr(input logic ps, input pport_index_type a, input logic [7:0] v);
    @(posedge clk);
    printer_port_select_n <= ps;
    register_index_lines  <= a;
    host_bus_in           <= v;
    io_write_strobe_n     <= 1'b0;
    repeat (2) @(posedge clk);
    io_write_strobe_n     <= 1'b1;
    printer_port_select_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Host read: answer is registered, so it is taken two edges after the strobe falls
  task automatic rd(input logic ps, input logic ss, input pport_index_type a);
    @(posedge clk);
    printer_port_select_n <= ps;
    serial_port_select_n  <= ss;
    register_index_lines  <= a;
    io_read_strobe_n      <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    d     = host_bus_out;
    oe_s  = host_bus_oe;
    dir_s = bus_buffer_direction;
    @(posedge clk);
    io_read_strobe_n      <= 1'b1;
    printer_port_select_n <= 1'b1;
    serial_port_select_n  <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the about 130 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      $display("BAD %0t run did not finish", $time);
      end_of_test();
    end
  end
  initial begin
    {rst_n, stall, no_paper, port_input_dir_enable, host_bus_in} = 12'h000;
    {printer_port_select_n, serial_port_select_n, io_write_strobe_n, io_read_strobe_n} = 4'hf;
    register_index_lines = 3'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(ctl_n, 8'h0f);
    check(printer_irq_oe, 1'b0);
    $display("reset test done");
    wr(1'b0, 3'h2, 8'h1f);
    check(ctl_n, 8'h00);
    check(printer_irq_oe, 1'b1);
    rd(1'b0, 1'b1, 3'h2);
    check(d, 8'h1f);
    check({oe_s, dir_s}, 8'h03);
    wr(1'b0, 3'h2, 8'h0a);
    check(ctl_n, 8'h0a);
    check(printer_irq_oe, 1'b0);
    $display("control test done");
    no_paper <= 1'b1;
    rd(1'b0, 1'b1, 3'h1);
    check(d & 8'hfb, 8'h70);
    no_paper <= 1'b0;
    rd(1'b0, 1'b1, 3'h1);
    check(d & 8'hfb, 8'h58);
    $display("status test done");
    rd(1'b1, 1'b1, 3'h2);
    check({oe_s, dir_s}, 8'h00);
    wr(1'b1, 3'h2, 8'h00);
    check(ctl_n, 8'h0a);
    rd(1'b1, 1'b0, 3'h0);
    check({oe_s, dir_s}, 8'h01);
    rd(1'b0, 1'b1, 3'h5);
    check(d, 8'h00);
    $display("select test done");
    stall <= 1'b1;
    wr(1'b0, 3'h0, 8'ha1);
    wr(1'b0, 3'h0, 8'hb2);
    check(data_write_ready, 1'b0);
    wr(1'b0, 3'h0, 8'hc3);
    check(printer_data_out, 8'h00);
    stall <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check(printer_data_out, 8'hb2);
    check(printer_data_oe, 1'b1);
    check(data_write_ready, 1'b1);
    rd(1'b0, 1'b1, 3'h0);
    check(d, 8'hb2);
    port_input_dir_enable <= 1'b1;
    rd(1'b0, 1'b1, 3'h0);
    check(printer_data_oe, 1'b0);
    check(d, 8'h3c);
    port_input_dir_enable <= 1'b0;
    $display("data test done");
    wr(1'b0, 3'h2, 8'h19);
    check(printer_irq, 1'b0);
    wr(1'b0, 3'h2, 8'h18);
    repeat (10) @(posedge clk);
    #1;
    check({printer_irq_oe, printer_irq}, 8'h03);
    check(irq_b, 1'b0);
    rd(1'b0, 1'b1, 3'h1);
    check(d & 8'h04, 8'h04);
    check(irq_b, 1'b1);
    $display("interrupt test done");
    end_of_test();
  end
endmodule
`default_nettype wire
